//--- hdl/pfsd_cfg.svh
// Strap defaults, bit positions, mode encodings and port indices for the strap default loader
`ifndef PFSD_CFG_SVH
`define PFSD_CFG_SVH

// ----------------------------------------------------------------
// Soft-strap defaults applied while no pin or loader value exists
// ----------------------------------------------------------------
`define PFSD_DEF_PORT2_DUPLEX   1'h1
`define PFSD_DEF_PORT2_SPEED    1'h1
`define PFSD_DEF_PORT2_AUTONEG  1'h1
`define PFSD_DEF_PORT2_BP       1'h1
`define PFSD_DEF_PORT2_PAUSE    1'h1
`define PFSD_DEF_PORT2_MANUAL   1'h0
`define PFSD_DEF_HOST_BP        1'h1
`define PFSD_DEF_HOST_PAUSE     1'h1
`define PFSD_DEF_HOST_MANUAL    1'h0
`define PFSD_DEF_HB_OFF         1'h0

// ----------------------------------------------------------------
// Register field positions
// ----------------------------------------------------------------
`define PFSD_ADV_10FD_BIT       6
`define PFSD_ADV_SYM_PAUSE_BIT  10
`define PFSD_ADV_WIDTH          16
`define PFSD_HEARTBEAT_TEST_OFF_BIT_BIT         0

// ----------------------------------------------------------------
// Special mode field encodings
// ----------------------------------------------------------------
`define PFSD_MODE_ALL_CAPABLE   3'h7
`define PFSD_MODE_FIXED_MSB     1'h0

// ----------------------------------------------------------------
// Port indices of the flow control bank
// ----------------------------------------------------------------
`define PFSD_PORT2_IDX          0
`define PFSD_HOST_IDX           1
`define PFSD_NUM_FLOW_PORTS     2

`endif

//--- hdl/pfsd_pkg.sv
// Types shared by the strap default loader files
package pfsd_pkg;

  typedef struct packed {
    logic port2_duplex;
    logic port2_speed;
    logic port2_autoneg;
    logic port2_bp;
    logic port2_pause;
    logic port2_manual;
    logic host_bp;
    logic host_pause;
    logic host_manual;
    logic hb_off;
  } pfsd_strap_set_type;

  typedef struct packed {
    logic manual;
    logic bp;
    logic tx;
    logic rx;
  } pfsd_flow_ctrl_type;

  typedef struct packed {
    logic       duplex;
    logic       adv_10fd;
    logic       adv_sym_pause;
    logic [2:0] mode;
  } pfsd_phy_bits_type;

  typedef struct packed {
    logic tx;
    logic rx;
  } pfsd_pause_pair_type;

  typedef enum logic [2:0] {
    ST_SAMPLE = 3'h1,
    ST_APPLY  = 3'h2,
    ST_RUN    = 3'h4
  } pfsd_state_type;

endpackage

//--- hdl/pfsd_strap_latch.sv
// Soft-strap holding register: pin capture or loader override
`timescale 1ns/1ps
`include "pfsd_cfg.svh"

module pfsd_strap_latch (
  input  wire logic                         clk_in,
  input  wire logic                         srst_in,
  input  wire logic                         capture_pins_in,
  input  wire logic                         capture_loader_in,
  input  wire pfsd_pkg::pfsd_strap_set_type pins_in,
  input  wire pfsd_pkg::pfsd_strap_set_type loader_in,
  output pfsd_pkg::pfsd_strap_set_type      straps_out
);

  // ----------------------------------------------------------------
  // Next value selection
  // ----------------------------------------------------------------
  pfsd_pkg::pfsd_strap_set_type next_straps;

  assign next_straps = capture_loader_in ? loader_in  :
                       capture_pins_in   ? pins_in    : straps_out;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Pins are caught after release, never inside the reset branch
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      straps_out.port2_duplex  <= `PFSD_DEF_PORT2_DUPLEX;
      straps_out.port2_speed   <= `PFSD_DEF_PORT2_SPEED;
      straps_out.port2_autoneg <= `PFSD_DEF_PORT2_AUTONEG;
      straps_out.port2_bp      <= `PFSD_DEF_PORT2_BP;
      straps_out.port2_pause   <= `PFSD_DEF_PORT2_PAUSE;
      straps_out.port2_manual  <= `PFSD_DEF_PORT2_MANUAL;
      straps_out.host_bp       <= `PFSD_DEF_HOST_BP;
      straps_out.host_pause    <= `PFSD_DEF_HOST_PAUSE;
      straps_out.host_manual   <= `PFSD_DEF_HOST_MANUAL;
      straps_out.hb_off        <= `PFSD_DEF_HB_OFF;
    end
    else
    begin
      straps_out <= next_straps;
    end
  end

endmodule // pfsd_strap_latch

//--- hdl/pfsd_top.sv
// Strap default loader for port 2, host port and virtual PHY register bits
`timescale 1ns/1ps
`include "pfsd_cfg.svh"

// Overview of operation
// - Duplex strap sets port 2 duplex default
// - Duplex strap sets 10FD advert, and mode when the autoneg strap is low
// - Backpressure strap sets port 2 backpressure default
// - Pause strap sets port 2 tx/rx pause
// - Manual low: auto-negotiated, symmetric pause advertised
// - Manual high: pause bits rule, no advert
// - Host backpressure strap sets host backpressure default
// - Host pause strap sets host tx/rx pause
// - Host manual strap picks virtual negotiation or bits
// - Heartbeat strap sets heartbeat test off bit
// - Loader values replace soft straps before use
module pfsd_top (
  input  wire logic                          SYS_CLK_IN,
  input  wire logic                          SRST_IN,
  input  wire pfsd_pkg::pfsd_strap_set_type  STRAP_PINS_IN,
  input  wire logic                          LOADER_REQ_IN,
  input  wire pfsd_pkg::pfsd_strap_set_type  LOADER_STRAPS_IN,
  input  wire logic                          PORT2_PHY_WR_IN,
  input  wire pfsd_pkg::pfsd_phy_bits_type   PORT2_PHY_WDATA_IN,
  input  wire logic                          PORT2_FLOW_WR_IN,
  input  wire pfsd_pkg::pfsd_flow_ctrl_type  PORT2_FLOW_WDATA_IN,
  input  wire logic                          HOST_FLOW_WR_IN,
  input  wire pfsd_pkg::pfsd_flow_ctrl_type  HOST_FLOW_WDATA_IN,
  input  wire logic                          VPHY_WR_IN,
  input  wire logic                          VPHY_WDATA_IN,
  input  wire pfsd_pkg::pfsd_pause_pair_type PORT2_AN_PAUSE_IN,
  input  wire pfsd_pkg::pfsd_pause_pair_type HOST_AN_PAUSE_IN,
  output logic                               LOADER_ACK_OUT,
  output logic                               LOAD_BUSY_OUT,
  output logic                               DEFAULTS_LOADED_OUT,
  output pfsd_pkg::pfsd_phy_bits_type        PORT2_PHY_OUT,
  output logic [`PFSD_ADV_WIDTH-1:0]         PORT2_ADV_BITS_OUT,
  output pfsd_pkg::pfsd_flow_ctrl_type       PORT2_FLOW_OUT,
  output pfsd_pkg::pfsd_flow_ctrl_type       HOST_FLOW_OUT,
  output logic                               HEARTBEAT_TEST_OFF_OUT,
  output pfsd_pkg::pfsd_pause_pair_type      PORT2_PAUSE_ACTIVE_OUT,
  output pfsd_pkg::pfsd_pause_pair_type      HOST_PAUSE_ACTIVE_OUT
);

  // ----------------------------------------------------------------
  // Load sequencer
  // ----------------------------------------------------------------
  pfsd_pkg::pfsd_state_type     state;
  pfsd_pkg::pfsd_state_type     next_state;
  pfsd_pkg::pfsd_strap_set_type straps;
  logic                         in_sample;
  logic                         in_apply;
  logic                         in_run;
  logic                         take_loader;

  assign in_sample   = (state == pfsd_pkg::ST_SAMPLE);
  assign in_apply    = (state == pfsd_pkg::ST_APPLY);
  assign in_run      = (state == pfsd_pkg::ST_RUN);
  // Loader holds its request until acknowledged, so no pulse is lost
  assign take_loader = in_run & LOADER_REQ_IN;

  always_comb
  begin
    next_state = state;
    unique case (state)
      pfsd_pkg::ST_SAMPLE : next_state = pfsd_pkg::ST_APPLY;
      pfsd_pkg::ST_APPLY  : next_state = pfsd_pkg::ST_RUN;
      pfsd_pkg::ST_RUN    :
      begin
        if (take_loader)
        begin
          next_state = pfsd_pkg::ST_APPLY;
        end
      end
      default             : next_state = pfsd_pkg::ST_SAMPLE;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SRST_IN)
    begin
      state <= pfsd_pkg::ST_SAMPLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign LOADER_ACK_OUT = take_loader;
  assign LOAD_BUSY_OUT  = ~in_run;

  // ----------------------------------------------------------------
  // Strap holding register
  // ----------------------------------------------------------------
  pfsd_strap_latch u_latch (
    .clk_in            (SYS_CLK_IN),
    .srst_in           (SRST_IN),
    .capture_pins_in   (in_sample),
    .capture_loader_in (take_loader),
    .pins_in           (STRAP_PINS_IN),
    .loader_in         (LOADER_STRAPS_IN),
    .straps_out        (straps)
  );

  // ----------------------------------------------------------------
  // Defaults derived from the straps
  // ----------------------------------------------------------------
  pfsd_pkg::pfsd_phy_bits_type  phy_default;
  pfsd_pkg::pfsd_flow_ctrl_type flow_default [`PFSD_NUM_FLOW_PORTS];
  pfsd_pkg::pfsd_flow_ctrl_type flow_wdata   [`PFSD_NUM_FLOW_PORTS];
  pfsd_pkg::pfsd_flow_ctrl_type flow         [`PFSD_NUM_FLOW_PORTS];
  logic                         flow_wr      [`PFSD_NUM_FLOW_PORTS];
  wire  [2:0]                   fixed_mode;

  assign phy_default.duplex        = straps.port2_duplex;
  assign phy_default.adv_10fd      = straps.port2_duplex;
  assign fixed_mode                = {`PFSD_MODE_FIXED_MSB, straps.port2_speed,
                                      straps.port2_duplex};
  assign phy_default.mode          = straps.port2_autoneg ? `PFSD_MODE_ALL_CAPABLE
                                                          : fixed_mode;
  assign phy_default.adv_sym_pause = ~straps.port2_manual;

  assign flow_default[`PFSD_PORT2_IDX] = '{manual: straps.port2_manual,
                                            bp:     straps.port2_bp,
                                            tx:     straps.port2_pause,
                                            rx:     straps.port2_pause};
  assign flow_default[`PFSD_HOST_IDX]  = '{manual: straps.host_manual,
                                            bp:     straps.host_bp,
                                            tx:     straps.host_pause,
                                            rx:     straps.host_pause};

  assign flow_wr[`PFSD_PORT2_IDX]    = PORT2_FLOW_WR_IN;
  assign flow_wr[`PFSD_HOST_IDX]     = HOST_FLOW_WR_IN;
  assign flow_wdata[`PFSD_PORT2_IDX] = PORT2_FLOW_WDATA_IN;
  assign flow_wdata[`PFSD_HOST_IDX]  = HOST_FLOW_WDATA_IN;

  // ----------------------------------------------------------------
  // Port 2 PHY bits
  // ----------------------------------------------------------------
  // Writes are ignored while a load is under way; the load wins
  logic phy_wr_ok;
  assign phy_wr_ok = in_run & PORT2_PHY_WR_IN;

  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SRST_IN)
    begin
      PORT2_PHY_OUT <= '0;
    end
    else if (in_apply)
    begin
      PORT2_PHY_OUT <= phy_default;
    end
    else if (phy_wr_ok)
    begin
      PORT2_PHY_OUT <= PORT2_PHY_WDATA_IN;
    end
  end

  always_comb
  begin
    PORT2_ADV_BITS_OUT                          = '0;
    PORT2_ADV_BITS_OUT[`PFSD_ADV_10FD_BIT]      = PORT2_PHY_OUT.adv_10fd;
    PORT2_ADV_BITS_OUT[`PFSD_ADV_SYM_PAUSE_BIT] = PORT2_PHY_OUT.adv_sym_pause;
  end

  // ----------------------------------------------------------------
  // Manual flow control banks, one per port
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PFSD_NUM_FLOW_PORTS; gi++)
    begin : g_flow
      always_ff @(posedge SYS_CLK_IN)
      begin
        if (SRST_IN)
        begin
          flow[gi] <= '0;
        end
        else if (in_apply)
        begin
          flow[gi] <= flow_default[gi];
        end
        else if (in_run & flow_wr[gi])
        begin
          flow[gi] <= flow_wdata[gi];
        end
      end
    end
  endgenerate

  assign PORT2_FLOW_OUT = flow[`PFSD_PORT2_IDX];
  assign HOST_FLOW_OUT  = flow[`PFSD_HOST_IDX];

  // Typed pairs; an untyped pattern has no type inside a conditional
  pfsd_pkg::pfsd_pause_pair_type p2_manual_pause;
  pfsd_pkg::pfsd_pause_pair_type host_manual_pause;
  assign p2_manual_pause   = '{tx: PORT2_FLOW_OUT.tx, rx: PORT2_FLOW_OUT.rx};
  assign host_manual_pause = '{tx: HOST_FLOW_OUT.tx, rx: HOST_FLOW_OUT.rx};

  assign PORT2_PAUSE_ACTIVE_OUT = PORT2_FLOW_OUT.manual ? p2_manual_pause
                                                        : PORT2_AN_PAUSE_IN;
  assign HOST_PAUSE_ACTIVE_OUT  = HOST_FLOW_OUT.manual ? host_manual_pause
                                                       : HOST_AN_PAUSE_IN;

  // ----------------------------------------------------------------
  // Virtual PHY heartbeat bit and load indication
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (SRST_IN)
    begin
      HEARTBEAT_TEST_OFF_OUT <= 1'h0;
      DEFAULTS_LOADED_OUT    <= 1'h0;
    end
    else
    begin
      DEFAULTS_LOADED_OUT <= in_apply;
      if (in_apply)
      begin
        HEARTBEAT_TEST_OFF_OUT <= straps.hb_off;
      end
      else if (in_run & VPHY_WR_IN)
      begin
        HEARTBEAT_TEST_OFF_OUT <= VPHY_WDATA_IN;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  sequence s_load;
    in_apply ##1 DEFAULTS_LOADED_OUT;
  endsequence

  sequence s_reload;
    take_loader ##1 in_apply;
  endsequence

  a_reset_load_done:
    assert property ($fell(SRST_IN) |-> ##1 in_apply ##1 DEFAULTS_LOADED_OUT)
    else $error("defaults not loaded two cycles after reset");

  a_duplex_default:
    assert property (in_apply |=> PORT2_PHY_OUT.duplex == $past(straps.port2_duplex))
    else $error("duplex bit differs from strap");

  a_adv_fd_default:
    assert property (s_load |-> PORT2_ADV_BITS_OUT[`PFSD_ADV_10FD_BIT]
                                == $past(straps.port2_duplex))
    else $error("10FD advert differs from duplex strap");

  a_mode_default:
    assert property (in_apply && !straps.port2_autoneg |=>
                     PORT2_PHY_OUT.mode == {1'h0, $past(straps.port2_speed),
                                            $past(straps.port2_duplex)})
    else $error("fixed mode field wrong");

  a_p2_bp_default:
    assert property (in_apply |=> PORT2_FLOW_OUT.bp == $past(straps.port2_bp))
    else $error("port 2 backpressure default wrong");

  a_p2_pause_default:
    assert property (in_apply |=> PORT2_FLOW_OUT.tx == $past(straps.port2_pause)
                                  && PORT2_FLOW_OUT.rx == $past(straps.port2_pause))
    else $error("port 2 pause defaults wrong");

  a_sym_pause_adv:
    assert property (s_load |-> PORT2_ADV_BITS_OUT[`PFSD_ADV_SYM_PAUSE_BIT]
                                != PORT2_FLOW_OUT.manual)
    else $error("symmetric pause advert not opposite of manual");

  a_p2_manual_follow:
    assert property (PORT2_FLOW_OUT.manual && $stable(PORT2_FLOW_OUT) |->
                     PORT2_PAUSE_ACTIVE_OUT.tx == $past(PORT2_FLOW_OUT.tx))
    else $error("manual port 2 pause not from bits");

  a_host_defaults:
    assert property (in_apply |=> HOST_FLOW_OUT.bp == $past(straps.host_bp)
                                  && HOST_FLOW_OUT.tx == $past(straps.host_pause)
                                  && HOST_FLOW_OUT.manual == $past(straps.host_manual))
    else $error("host flow defaults wrong");

  a_host_an_follow:
    assert property (!HOST_FLOW_OUT.manual |-> HOST_PAUSE_ACTIVE_OUT == HOST_AN_PAUSE_IN)
    else $error("host pause not from virtual negotiation");

  a_hb_default:
    assert property (in_apply |=> HEARTBEAT_TEST_OFF_OUT == $past(straps.hb_off))
    else $error("heartbeat off bit default wrong");

  a_loader_override:
    assert property (s_reload |-> ##1 PORT2_PHY_OUT.duplex
                                 == $past(LOADER_STRAPS_IN.port2_duplex, 2))
    else $error("loader duplex value not applied");

  a_write_sticks:
    assert property (in_run && VPHY_WR_IN && !take_loader |=>
                     HEARTBEAT_TEST_OFF_OUT == $past(VPHY_WDATA_IN) ##1
                     (HEARTBEAT_TEST_OFF_OUT == $past(VPHY_WDATA_IN, 2)
                      || $past(VPHY_WR_IN) || $past(in_apply)))
    else $error("software write lost or overridden");

endmodule // pfsd_top

//--- tb/pfsd_loader_model.sv
// Behavioural strap loader model on the far side of the loader handshake
`timescale 1ns/1ps

module pfsd_loader_model (
  input  wire logic                    clk_in,
  input  wire logic                    ack_in,
  output pfsd_pkg::pfsd_strap_set_type straps_out,
  output logic                         req_out
);
  initial
  begin
    req_out    = 1'h0;
    straps_out = '0;
  end

  // ----------------------------------------------------------------
  // Request handshake
  // ----------------------------------------------------------------
  // Loader word replaces pin straps
  task automatic load(input pfsd_pkg::pfsd_strap_set_type v, input int gap, output bit ok);
    int i;
    ok = 1'h0;
    repeat (gap) @(negedge clk_in);
    @(negedge clk_in);
    req_out    = 1'h1;
    straps_out = v;
    for (i = 0; i < 16 && !ok; i++)
    begin
      @(posedge clk_in);
      if (ack_in === 1'h1)
        ok = 1'h1;
    end
    @(negedge clk_in);
    req_out    = 1'h0;
    // Released word is not held; inverse keeps stale data from passing
    straps_out = ~v;
  endtask
endmodule // pfsd_loader_model

//--- tb/tb_pfsd_top.sv
// Self-checking bench for the strap default loader
`timescale 1ns/1ps
`include "pfsd_cfg.svh"

`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end

module tb_pfsd_top;
  logic                          clk;
  logic                          srst;
  pfsd_pkg::pfsd_strap_set_type  pins;
  logic                          ld_req;
  pfsd_pkg::pfsd_strap_set_type  ld_straps;
  logic                          phy_wr;
  pfsd_pkg::pfsd_phy_bits_type   phy_wd;
  logic                          p2_wr;
  pfsd_pkg::pfsd_flow_ctrl_type  p2_wd;
  logic                          h_wr;
  pfsd_pkg::pfsd_flow_ctrl_type  h_wd;
  logic                          vp_wr;
  logic                          vp_wd;
  pfsd_pkg::pfsd_pause_pair_type p2_an;
  pfsd_pkg::pfsd_pause_pair_type h_an;
  logic                          ack;
  logic                          busy;
  logic                          loaded;
  pfsd_pkg::pfsd_phy_bits_type   phy;
  logic [15:0]                   adv;
  pfsd_pkg::pfsd_flow_ctrl_type  p2_fl;
  pfsd_pkg::pfsd_flow_ctrl_type  h_fl;
  logic                          hb;
  pfsd_pkg::pfsd_pause_pair_type p2_act;
  pfsd_pkg::pfsd_pause_pair_type h_act;
  int                            n_fail;
  int                            comparisons;
  int                            cycles;

  pfsd_top uut (.SYS_CLK_IN(clk), .SRST_IN(srst), .STRAP_PINS_IN(pins),
    .LOADER_REQ_IN(ld_req), .LOADER_STRAPS_IN(ld_straps), .PORT2_PHY_WR_IN(phy_wr),
    .PORT2_PHY_WDATA_IN(phy_wd), .PORT2_FLOW_WR_IN(p2_wr), .PORT2_FLOW_WDATA_IN(p2_wd),
    .HOST_FLOW_WR_IN(h_wr), .HOST_FLOW_WDATA_IN(h_wd), .VPHY_WR_IN(vp_wr),
    .VPHY_WDATA_IN(vp_wd), .PORT2_AN_PAUSE_IN(p2_an), .HOST_AN_PAUSE_IN(h_an),
    .LOADER_ACK_OUT(ack), .LOAD_BUSY_OUT(busy), .DEFAULTS_LOADED_OUT(loaded),
    .PORT2_PHY_OUT(phy), .PORT2_ADV_BITS_OUT(adv), .PORT2_FLOW_OUT(p2_fl),
    .HOST_FLOW_OUT(h_fl), .HEARTBEAT_TEST_OFF_OUT(hb), .PORT2_PAUSE_ACTIVE_OUT(p2_act),
    .HOST_PAUSE_ACTIVE_OUT(h_act));

  pfsd_loader_model ldr (.clk_in(clk), .ack_in(ack), .straps_out(ld_straps),
    .req_out(ld_req));

  // ----------------------------------------------------------------
  // Clock, timeout and verdict
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Whole run needs under a hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic wait_loaded();
    int i;
    for (i = 0; i < 10 && loaded !== 1'h1; i++)
      @(negedge clk);
    `CHK("loaded", 1'h1, loaded)
  endtask

  task automatic do_reset(input pfsd_pkg::pfsd_strap_set_type p);
    @(negedge clk);
    srst = 1'h1;
    pins = p;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    wait_loaded();
  endtask

  // Expected defaults worked out from one strap word
  task automatic check_all(input pfsd_pkg::pfsd_strap_set_type s);
    pfsd_pkg::pfsd_phy_bits_type e;
    logic [15:0]                 ea;
    e.duplex        = s.port2_duplex;
    e.adv_10fd      = s.port2_duplex;
    e.adv_sym_pause = ~s.port2_manual;
    e.mode = s.port2_autoneg ? 3'h7 : {1'h0, s.port2_speed, s.port2_duplex};
    ea = 16'h0;
    ea[6]  = s.port2_duplex;
    ea[10] = ~s.port2_manual;
    `CHK("phy", e, phy)
    `CHK("adv", ea, adv)
    `CHK("p2_flow", {s.port2_manual, s.port2_bp, s.port2_pause, s.port2_pause}, p2_fl)
    `CHK("h_flow", {s.host_manual, s.host_bp, s.host_pause, s.host_pause}, h_fl)
    `CHK("hb_off", s.hb_off, hb)
  endtask

  // Pause source follows the manual select bit, both ports
  task automatic check_pause();
    int i;
    for (i = 0; i < 4; i++)
    begin
      @(negedge clk);
      p2_an = i[1:0];
      h_an  = ~i[1:0];
      #1;
      `CHK("p2_act", p2_fl.manual ? {p2_fl.tx, p2_fl.rx} : p2_an, p2_act)
      `CHK("h_act", h_fl.manual ? {h_fl.tx, h_fl.rx} : h_an, h_act)
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Pin defaults across several strap words
  task automatic sc_pin_defaults();
    pfsd_pkg::pfsd_strap_set_type tbl [3];
    int i;
    tbl = '{10'h3e6, 10'h119, 10'h2aa};
    for (i = 0; i < 3; i++)
    begin
      do_reset(tbl[i]);
      `CHK("busy", 1'h0, busy)
      check_all(tbl[i]);
      check_pause();
    end
  endtask

  task automatic sc_writes();
    @(negedge clk);
    phy_wr = 1'h1;
    phy_wd = 6'h2a;
    p2_wr  = 1'h1;
    p2_wd  = 4'hb;
    h_wr   = 1'h1;
    h_wd   = 4'h4;
    vp_wr  = 1'h1;
    vp_wd  = ~hb;
    @(negedge clk);
    phy_wr = 1'h0;
    p2_wr  = 1'h0;
    h_wr   = 1'h0;
    vp_wr  = 1'h0;
    repeat (5) @(negedge clk);
    `CHK("phy_wr", 6'h2a, phy)
    `CHK("p2_wr", 4'hb, p2_fl)
    `CHK("h_wr", 4'h4, h_fl)
    `CHK("vp_wr", vp_wd, hb)
    check_pause();
  endtask

  // Loader word overrides pins, write during apply is lost
  task automatic sc_loader(input pfsd_pkg::pfsd_strap_set_type v, input int gap);
    bit ok;
    fork
      ldr.load(v, gap, ok);
      begin
        @(posedge clk iff ack === 1'h1);
        @(negedge clk);
        `CHK("busy_apply", 1'h1, busy)
        `CHK("ack_busy", 1'h0, ack)
        p2_wr = 1'h1;
        p2_wd = ~{v.port2_manual, v.port2_bp, v.port2_pause, v.port2_pause};
        @(negedge clk);
        p2_wr = 1'h0;
      end
    join
    `CHK("ack", 1'h1, ok)
    `CHK("loaded_now", 1'h1, loaded)
    check_all(v);
  endtask

  // Mid-run reset reloads pin defaults over software values
  task automatic sc_mid_reset(input pfsd_pkg::pfsd_strap_set_type p);
    do_reset(p);
    `CHK("busy_rst", 1'h0, busy)
    check_all(p);
  endtask

  initial
  begin
    srst   = 1'h1;
    pins   = 10'h3e6;
    phy_wr = 1'h0;
    phy_wd = 6'h0;
    p2_wr  = 1'h0;
    p2_wd  = 4'h0;
    h_wr   = 1'h0;
    h_wd   = 4'h0;
    vp_wr  = 1'h0;
    vp_wd  = 1'h0;
    p2_an  = 2'h0;
    h_an   = 2'h0;
    n_fail = 0;
    comparisons = 0;
    cycles = 0;
    sc_pin_defaults();
    sc_writes();
    sc_loader(10'h155, 0);
    sc_loader(10'h0ee, 3);
    sc_writes();
    sc_mid_reset(10'h3e6);
    stop_test();
  end
endmodule // tb_pfsd_top
